// *** fru_unit.sv ***
// Float format, negation, conversion, compare and rounding unit
//
// Contract
// RULE1 - Operands come in half, single and double precision: sign, exponent, fraction.
// RULE2 - Sign bit is one exactly when the value is negative.
// RULE3 - Exponent biases are 16, 256 and 16384 for half, single, double.
// RULE4 - Negative values store the one's complement of the biased exponent.
// RULE5 - Mantissa magnitude lies in [1,2); hidden bit is the inverted sign.
// RULE6 - Zero is the all-zero word, outside the normalised format.
// RULE7 - Negation is two's-complement of the whole word.
// RULE8 - Integer to float drops the leading one, left-justifies the rest.
// RULE9 - Times one is identity; add and multiply commute; adding negation subtracts.
// RULE10 - Extreme values share patterns with largest integer, its negation, +1, -1.
// RULE11 - Sign-only pattern is the invalid value, illegal to every operation.
// RULE12 - Floats are ordered by signed integer compare of their encodings.
// RULE13 - Invalid compares lowest; min negative sits above negatives, below zero.
// RULE14 - Float to integer uses its own modifier; others use rounding_control.
// RULE15 - Read and write operations return and update rounding_control.
// RULE16 - Residue is the distance from the floor candidate, in result lsbs.
// RULE17 - Bit 1 set rounds to nearest; exact halves use bits 2-4; bit0 reserved.
// RULE18 - Bit 1 clear: nonzero residue uses bits 2-4, zero is exact.
// RULE19 - Bit 2 picks base direction: zero down, one up.
// RULE20 - Bit 3 reverses direction when the lower candidate lsb is one.
// RULE21 - Bit 4 reverses direction when the result is negative; reversals accumulate.
// RULE22 - Codes 0 floor, 1 to zero, 4 ceiling, 5 away, 12 stable, 14 half up.
// RULE23 - Carry out of the fraction renormalises by bumping the exponent.
`timescale 1ns/1ps
module fru_unit #(
  parameter logic [4:0] RC_RESET = fru_pkg::RC_HALF_UP
) (
  input  wire logic             sys_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             req_valid_in,
  input  wire fru_pkg::fru_req_t req_in,
  output logic                  rsp_valid_out,
  output fru_pkg::fru_rsp_t     rsp_out,
  output logic [4:0]            rounding_control_out
);

  // Sign-extend a right-aligned word of the given precision
  function automatic logic [71:0] sext(input logic [71:0] v, input fru_pkg::fru_prec_t p);
    case (p)
      fru_pkg::FRU_HALF:   sext = {{54{v[17]}}, v[17:0]};
      fru_pkg::FRU_SINGLE: sext = {{36{v[35]}}, v[35:0]};
      default:             sext = v;
    endcase
  endfunction : sext

  // Largest integer of a precision
  function automatic logic [71:0] max_pos(input fru_pkg::fru_prec_t p);
    case (p)
      fru_pkg::FRU_HALF:   max_pos = fru_pkg::HALF_MAX;
      fru_pkg::FRU_SINGLE: max_pos = fru_pkg::SINGLE_MAX;
      default:             max_pos = fru_pkg::DOUBLE_MAX;
    endcase
  endfunction : max_pos

  fru_pkg::fru_req_t rq;
  logic [4:0]   rc_reg;
  logic [4:0]   rc_next;
  logic         rc_we;
  fru_pkg::fru_rsp_t rsp_reg;
  fru_pkg::fru_rsp_t rsp_next;
  logic         rsp_valid_reg;

  logic [71:0]  sa;
  logic [71:0]  sb;
  logic [71:0]  invalid_pat;
  logic         a_invalid;
  logic         b_invalid;
  logic [71:0]  mag;
  logic         neg;
  logic [6:0]   lz;
  logic [6:0]   top_pos;
  logic [71:0]  norm;
  logic [15:0]  ev;
  logic [143:0] ext;
  logic [143:0] ext_s;
  logic [143:0] ext_r;
  logic [15:0]  fix_exp;
  logic [15:0]  bias;
  logic [71:0]  fraction_field_l;
  logic signed [16:0] xs;
  logic signed [16:0] sh;
  logic         fix_sat;
  logic [71:0]  cand;
  logic [71:0]  bumped;
  logic         res_guard;
  logic         res_sticky;
  logic [4:0]   mode;
  logic         round_up;
  logic         inexact;
  int unsigned  width;

  assign rq = req_in;

  // RULE11 sign-only pattern of the operand precision
  assign invalid_pat = sext(72'h80_0000_0000_0000_0000 >> (fru_pkg::WORD_W - width), rq.prec);
  assign sa          = sext(rq.a, rq.prec);
  assign sb          = sext(rq.b, rq.prec);
  assign a_invalid   = (sa == invalid_pat);
  assign b_invalid   = (sb == invalid_pat);

  // RULE1 per-precision widths and biases
  always_comb begin
    case (rq.prec)
      fru_pkg::FRU_HALF: begin
        width = fru_pkg::HALF_W;
        bias  = fru_pkg::HALF_BIAS;
      end
      fru_pkg::FRU_SINGLE: begin
        width = fru_pkg::SINGLE_W;
        bias  = fru_pkg::SINGLE_BIAS;
      end
      default: begin
        width = fru_pkg::DOUBLE_W;
        bias  = fru_pkg::DOUBLE_BIAS;
      end
    endcase
  end

  // Magnitude of the operand; RULE7 float magnitude by whole-word negation
  assign neg = sa[71];
  assign mag = neg ? 72'(-sa) : sa;

  fru_lead_one #(
    .W  (fru_pkg::WORD_W),
    .CW (7)
  ) u_lead_one (
    .vec_in         (mag),
    .lead_zeros_out (lz)
  );

  // RULE8 drop the leading one and left-justify the rest
  assign top_pos = 7'd71 - lz;
  assign norm    = mag << lz;
  // RULE3 biased exponent of the converted integer
  assign ev      = 16'(top_pos) + bias;

  // Exponent field and fraction of the magnitude operand for float to integer
  always_comb begin
    case (rq.prec)
      fru_pkg::FRU_HALF: begin
        fix_exp = 16'(mag[16:12]);
        fraction_field_l  = {1'b1, mag[11:0], 59'h0};
      end
      fru_pkg::FRU_SINGLE: begin
        fix_exp = 16'(mag[34:26]);
        fraction_field_l  = {1'b1, mag[25:0], 45'h0};
      end
      default: begin
        fix_exp = 16'(mag[70:56]);
        fraction_field_l  = {1'b1, mag[55:0], 15'h0};
      end
    endcase
  end

  // RULE5 hidden one restored; unbiased exponent sets the binary point
  assign xs      = $signed({1'b0, fix_exp}) - $signed({1'b0, bias});
  assign sh      = xs + 17'sd1;
  assign fix_sat = (xs >= $signed(17'(width - 1)));

  // Extended exact value: candidate word above, residue below bit 72
  always_comb begin
    ext   = '0;
    ext_r = '0;
    if (rq.op == fru_pkg::FRU_OP_FLOAT && mag != 72'h0) begin
      // RULE2 RULE4 positive form first, negated afterwards
      case (rq.prec)
        fru_pkg::FRU_HALF:   ext = {1'b0, ev[4:0], norm[70:0], 67'h0};
        fru_pkg::FRU_SINGLE: ext = {1'b0, ev[8:0], norm[70:0], 63'h0};
        default:             ext = {1'b0, ev[14:0], norm[70:0], 57'h0};
      endcase
    end else if (rq.op == fru_pkg::FRU_OP_FIX && mag != 72'h0) begin
      if (sh >= 0) begin
        ext = {72'h0, fraction_field_l} << sh[7:0];
      end else if (-sh < 17'sd144) begin
        ext = {72'h0, fraction_field_l} >> 8'(-sh);
      end
    end
    ext_s = neg ? 144'(-ext) : ext;
    case (rq.op)
      fru_pkg::FRU_OP_FLOAT: begin
        // Right-align the encoding, keeping the residue below bit 72
        case (rq.prec)
          fru_pkg::FRU_HALF:   ext_r = 144'($signed(ext_s) >>> 54);
          fru_pkg::FRU_SINGLE: ext_r = 144'($signed(ext_s) >>> 36);
          default:             ext_r = ext_s;
        endcase
      end
      fru_pkg::FRU_OP_FIX: ext_r = ext_s;
      default: ext_r = {sa, rq.guard, rq.sticky, 70'h0};
    endcase
  end

  // RULE16 floor candidate and residue bits
  assign cand       = ext_r[143:72];
  assign res_guard  = ext_r[71];
  assign res_sticky = |ext_r[70:0];

  // RULE14 conversion to integer rounds by its own modifier
  assign mode = (rq.op == fru_pkg::FRU_OP_FIX) ? rq.fix_mode : rc_reg;

  fru_round_dec u_round_dec (
    .mode_in      (mode),
    .lsb_in       (cand[0]),
    .guard_in     (res_guard),
    .sticky_in    (res_sticky),
    .negative_in  (cand[71]),
    .round_up_out (round_up),
    .inexact_out  (inexact)
  );

  // RULE23 integer increment carries into the exponent
  assign bumped = cand + 72'(round_up);

  // Result selection per operation
  always_comb begin
    rsp_next = '0;
    case (rq.op)
      fru_pkg::FRU_OP_NEG: begin
        // RULE7 whole-word negation
        rsp_next.result  = sext(72'(-sa), rq.prec);
        rsp_next.invalid = a_invalid;
      end
      fru_pkg::FRU_OP_FLOAT: begin
        // RULE6 zero integer gives the all-zero word
        rsp_next.result  = sext(bumped, rq.prec);
        rsp_next.inexact = inexact;
        // RULE10 saturate at the largest value rather than wrap
        if (cand == max_pos(rq.prec) && round_up) begin
          rsp_next.result = cand;
        end
      end
      fru_pkg::FRU_OP_FIX: begin
        rsp_next.invalid = a_invalid;
        rsp_next.inexact = inexact;
        rsp_next.result  = bumped;
        if (a_invalid || fix_sat || sext(bumped, rq.prec) != bumped) begin
          rsp_next.overflow = 1'b1;
          rsp_next.result   = neg ? 72'(-max_pos(rq.prec)) : max_pos(rq.prec);
        end
      end
      fru_pkg::FRU_OP_ROUND: begin
        // RULE9 rounding depends only on the exact value, not operand order
        rsp_next.invalid = a_invalid;
        rsp_next.inexact = inexact;
        rsp_next.result  = sext(bumped, rq.prec);
        if (cand == max_pos(rq.prec) && round_up) begin
          rsp_next.result = cand;
        end
      end
      fru_pkg::FRU_OP_CMP: begin
        // RULE12 RULE13 plain signed compare of encodings
        rsp_next.less  = ($signed(sa) < $signed(sb));
        rsp_next.equal = (sa == sb);
      end
      fru_pkg::FRU_OP_RDRC: begin
        // RULE15 read of the control field
        rsp_next.result = 72'(rc_reg);
      end
      fru_pkg::FRU_OP_WRRC: begin
        rsp_next.reserved_err = rq.a[fru_pkg::RC_RSV];
      end
      default: rsp_next = '0;
    endcase
  end

  // RULE15 write of the control field; RULE17 reserved bit held at zero
  assign rc_we   = req_valid_in && (rq.op == fru_pkg::FRU_OP_WRRC);
  assign rc_next = {1'b0, rq.a[3:0]};

  // Rounding control register
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rc_reg <= {1'b0, RC_RESET[3:0]};
    end else if (rc_we) begin
      rc_reg <= rc_next;
    end
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rsp_reg       <= '0;
      rsp_valid_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= req_valid_in;
      if (req_valid_in) begin
        rsp_reg <= rsp_next;
      end
    end
  end

  assign rsp_out              = rsp_reg;
  assign rsp_valid_out        = rsp_valid_reg;
  assign rounding_control_out = rc_reg;

  // RULE17 reserved bit never set
  AST_RC_RSV_ZERO: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rc_reg[fru_pkg::RC_RSV] == 1'b0) else $error("reserved rounding bit set"); // RULE17

  // RULE15 write lands next cycle
  AST_RC_WRITE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    rc_we |=> rc_reg == {1'b0, $past(rq.a[3:0])}) else $error("rounding write lost"); // RULE15

  // RULE15 read returns the field
  AST_RC_READ: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_RDRC
    |=> rsp_valid_out && rsp_out.result == 72'($past(rc_reg))) else $error("bad read"); // RULE15

  // RULE7 double-precision negation is exact two's complement
  AST_NEG_WORD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_NEG && rq.prec == fru_pkg::FRU_DOUBLE
    |=> rsp_out.result + $past(rq.a) == 72'h0) else $error("negation wrong"); // RULE7

  // RULE12 compare follows signed integer order
  AST_CMP_ORDER: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_CMP
    |=> rsp_out.less == ($signed($past(sa)) < $signed($past(sb)))) else $error("compare"); // RULE12

  // RULE13 invalid compares below everything else
  AST_NAN_LOWEST: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_CMP && a_invalid && !b_invalid
    |=> rsp_out.less && !rsp_out.equal) else $error("invalid not lowest"); // RULE13

  // RULE11 invalid operand flagged
  AST_INVALID_FLAG: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_NEG && a_invalid
    |=> rsp_out.invalid && rsp_out.result == $past(sa)) else $error("invalid missed"); // RULE11

  // RULE18 exact residue delivers the candidate
  AST_EXACT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_ROUND && !rq.guard && !rq.sticky
    |=> rsp_out.result == $past(sa) && !rsp_out.inexact) else $error("exact changed"); // RULE18

  // RULE22 floor never rounds up
  AST_FLOOR: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_ROUND && rc_reg == fru_pkg::RC_FLOOR
    |=> rsp_out.result == $past(sa)) else $error("floor rounded up"); // RULE22

  // RULE19 ceiling rounds inexact results up
  AST_CEIL: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_ROUND && rc_reg == fru_pkg::RC_CEIL
    && rq.sticky && rq.prec == fru_pkg::FRU_HALF && sa != fru_pkg::HALF_MAX
    |=> rsp_out.result == $past(sa) + 72'h1) else $error("ceiling missed"); // RULE19

  // RULE6 zero integer converts to the zero word
  AST_FLOAT_ZERO: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in && rq.op == fru_pkg::FRU_OP_FLOAT && sa == 72'h0
    |=> rsp_out.result == 72'h0 && !rsp_out.inexact) else $error("zero not zero"); // RULE6

  // Answer valid exactly one cycle after each request
  AST_ANSWER_TIMING: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    req_valid_in |=> rsp_valid_out) else $error("answer late");

endmodule : fru_unit

// *** fru_pkg.sv ***
// Shared constants, encodings and carrier types for the float format and rounding unit
package fru_pkg;

  // Datapath word and operand widths per precision
  localparam int unsigned WORD_W   = 72;
  localparam int unsigned HALF_W   = 18;
  localparam int unsigned SINGLE_W = 36;
  localparam int unsigned DOUBLE_W = 72;

  // Exponent excess biases per precision
  localparam logic [15:0] HALF_BIAS   = 16'h0010;
  localparam logic [15:0] SINGLE_BIAS = 16'h0100;
  localparam logic [15:0] DOUBLE_BIAS = 16'h4000;

  // Vector index of each rounding_control bit; control bit 0 is the most significant
  localparam int unsigned RC_RSV  = 4;
  localparam int unsigned RC_NEAR = 3;
  localparam int unsigned RC_DIR  = 2;
  localparam int unsigned RC_LSB  = 1;
  localparam int unsigned RC_SIGN = 0;

  // Common rounding_control codes (octal 0, 1, 4, 5, 12, 14)
  localparam logic [4:0] RC_FLOOR   = 5'h00;
  localparam logic [4:0] RC_TO_ZERO = 5'h01;
  localparam logic [4:0] RC_CEIL    = 5'h04;
  localparam logic [4:0] RC_AWAY    = 5'h05;
  localparam logic [4:0] RC_STABLE  = 5'h0a;
  localparam logic [4:0] RC_HALF_UP = 5'h0c;

  // Largest integer of each precision, right aligned
  localparam logic [71:0] HALF_MAX   = 72'h00_0000_0000_0001_ffff;
  localparam logic [71:0] SINGLE_MAX = 72'h00_0000_0007_ffff_ffff;
  localparam logic [71:0] DOUBLE_MAX = 72'h7f_ffff_ffff_ffff_ffff;

  // Operand precision, one-hot
  typedef enum logic [2:0] {
    FRU_HALF   = 3'b001,
    FRU_SINGLE = 3'b010,
    FRU_DOUBLE = 3'b100
  } fru_prec_t;

  // Operations accepted from the pipeline, one-hot
  typedef enum logic [6:0] {
    FRU_OP_NEG   = 7'b0000001,
    FRU_OP_FLOAT = 7'b0000010,
    FRU_OP_FIX   = 7'b0000100,
    FRU_OP_ROUND = 7'b0001000,
    FRU_OP_CMP   = 7'b0010000,
    FRU_OP_RDRC  = 7'b0100000,
    FRU_OP_WRRC  = 7'b1000000
  } fru_op_t;

  // Request from the instruction pipeline
  typedef struct packed {
    fru_op_t    op;
    fru_prec_t  prec;
    logic [71:0] a;
    logic [71:0] b;
    logic        guard;
    logic        sticky;
    logic [4:0]  fix_mode;
  } fru_req_t;

  // Answer to the instruction pipeline
  typedef struct packed {
    logic [71:0] result;
    logic        invalid;
    logic        inexact;
    logic        overflow;
    logic        less;
    logic        equal;
    logic        reserved_err;
  } fru_rsp_t;

endpackage : fru_pkg

// *** fru_lead_one.sv ***
// Leading-one locator used to normalise integers
`timescale 1ns/1ps
module fru_lead_one #(
  parameter int unsigned W  = 72,
  parameter int unsigned CW = 7
) (
  input  wire logic [W-1:0]  vec_in,
  output logic      [CW-1:0] lead_zeros_out
);

  // Highest set bit wins, as it is visited last
  always_comb begin
    lead_zeros_out = '0;
    for (int i = 0; i < W; i++) begin
      if (vec_in[i]) begin
        lead_zeros_out = CW'(W - 1 - i);
      end
    end
  end

endmodule : fru_lead_one

// *** fru_round_dec.sv ***
// Rounding decision from the control field and the residue
`timescale 1ns/1ps
module fru_round_dec (
  input  wire logic [4:0] mode_in,
  input  wire logic       lsb_in,
  input  wire logic       guard_in,
  input  wire logic       sticky_in,
  input  wire logic       negative_in,
  output logic            round_up_out,
  output logic            inexact_out
);

  logic direction;
  logic half_exact;
  logic above_half;

  // Base direction with accumulated reversals
  always_comb begin
    // RULE19 base direction
    direction = mode_in[fru_pkg::RC_DIR];
    // RULE20 parity reversal
    direction = direction ^ (mode_in[fru_pkg::RC_LSB] & lsb_in);
    // RULE21 sign reversal
    direction = direction ^ (mode_in[fru_pkg::RC_SIGN] & negative_in);
  end

  // Residue classification against one half of an lsb
  assign half_exact  = guard_in & ~sticky_in;
  assign above_half  = guard_in & sticky_in;
  assign inexact_out = guard_in | sticky_in;

  // Pick upper or lower candidate
  always_comb begin
    if (mode_in[fru_pkg::RC_NEAR]) begin
      // RULE17 nearest, ties by direction
      round_up_out = half_exact ? direction : above_half;
    end else begin
      // RULE18 directed when inexact
      round_up_out = inexact_out & direction;
    end
  end

endmodule : fru_round_dec

// *** fru_pipe_model.sv ***
// Pipeline-side model that issues queued requests and gathers answers
`timescale 1ns/1ps
module fru_pipe_model (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              rsp_valid_in,
  input  wire fru_pkg::fru_rsp_t rsp_in,
  output logic                   req_valid_out,
  output fru_pkg::fru_req_t      req_out
);
  fru_pkg::fru_req_t req_q [$];
  fru_pkg::fru_rsp_t rsp_q [$];

  // Quiet lines at time zero
  initial begin
    req_valid_out = 1'b0;
    req_out       = '0;
  end

  // One request a cycle; idle lines toggle so stale values never pass as fresh
  always @(posedge clk_in) begin
    if (!rst_in && req_q.size() > 0) begin
      req_valid_out <= 1'b1;
      req_out       <= req_q.pop_front();
    end else begin
      req_valid_out <= 1'b0;
      req_out       <= fru_pkg::fru_req_t'(~req_out);
    end
  end

  // Answers are collected mid-cycle, while they stand
  always @(negedge clk_in) begin
    if (rsp_valid_in === 1'b1) rsp_q.push_back(rsp_in);
  end
endmodule : fru_pipe_model

// *** fru_unit_test.sv ***
// Self-checking bench for the float format and rounding unit
`timescale 1ns/1ps
module fru_unit_test;
  logic              sys_clk_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic              req_valid;
  fru_pkg::fru_req_t req;
  logic              rsp_valid_out;
  fru_pkg::fru_rsp_t rsp_out;
  logic [4:0]        rounding_control_out;
  fru_pkg::fru_rsp_t r;
  logic [71:0]       v, n, ex;
  logic              g, s, u;
  logic [4:0]        rc;
  int                miscompares = 0;
  int                checked = 0;
  int                seed;
  int                e;
  logic [4:0]  modes [6] = '{fru_pkg::RC_FLOOR, fru_pkg::RC_TO_ZERO, fru_pkg::RC_CEIL,
                             fru_pkg::RC_AWAY, fru_pkg::RC_STABLE, fru_pkg::RC_HALF_UP};
  logic [71:0] nv [5] = '{72'o232000, 72'o232001, 72'o546001, 72'o233777, 72'h1ffff};
  logic [71:0] sp [6] = '{~fru_pkg::SINGLE_MAX, -fru_pkg::SINGLE_MAX, '1, '0, 72'h1,
                          fru_pkg::SINGLE_MAX};
  fru_pkg::fru_prec_t pr [3] = '{fru_pkg::FRU_HALF, fru_pkg::FRU_SINGLE, fru_pkg::FRU_DOUBLE};
  int          wds [3] = '{18, 36, 72};
  int          fws [3] = '{12, 26, 56};
  int          bss [3] = '{16, 256, 16384};

  // Free-running 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;

  fru_unit uut (
    .sys_clk_in           (sys_clk_in),
    .sys_rst_in           (sys_rst_in),
    .req_valid_in         (req_valid),
    .req_in               (req),
    .rsp_valid_out        (rsp_valid_out),
    .rsp_out              (rsp_out),
    .rounding_control_out (rounding_control_out)
  );

  fru_pipe_model pipe (
    .clk_in        (sys_clk_in),
    .rst_in        (sys_rst_in),
    .rsp_valid_in  (rsp_valid_out),
    .rsp_in        (rsp_out),
    .req_valid_out (req_valid),
    .req_out       (req)
  );

  // Verdict and end of run
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // Compare of a result word
  task automatic cmp_word(input logic [71:0] got, input logic [71:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  // Compare of a flag
  task automatic cmp_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag

  // Queue one request for the pipeline model
  task automatic put(input fru_pkg::fru_op_t op, input fru_pkg::fru_prec_t p,
                     input logic [71:0] a, input logic [71:0] b = '0, input logic gd = 1'b0,
                     input logic st = 1'b0, input logic [4:0] fm = 5'h00);
    fru_pkg::fru_req_t q;
    q = '{op, p, a, b, gd, st, fm};
    pipe.req_q.push_back(q);
  endtask : put

  // Wait, bounded, for the next answer
  task automatic take();
    int k;
    k = 0;
    while (pipe.rsp_q.size() == 0 && k < 20) begin
      @(posedge sys_clk_in);
      #5;
      k++;
    end
    if (pipe.rsp_q.size() == 0) begin
      miscompares++;
      $display("mismatch at %0t: no answer", $time);
    end else r = pipe.rsp_q.pop_front();
  endtask : take

  task automatic run(input fru_pkg::fru_op_t op, input fru_pkg::fru_prec_t p,
                     input logic [71:0] a, input logic [71:0] b = '0, input logic gd = 1'b0,
                     input logic st = 1'b0, input logic [4:0] fm = 5'h00);
    put(op, p, a, b, gd, st, fm);
    take();
  endtask : run

  // Sign extension from a precision width
  function automatic logic [71:0] sx(input logic [71:0] x, input int w);
    logic [71:0] m;
    m = (72'h1 << w) - 72'h1;
    return x[w-1] ? ((x & m) | ~m) : (x & m);
  endfunction : sx

  function automatic logic up_f(input logic [4:0] c, input logic l, input logic gd,
                                input logic st, input logic ng);
    if (!gd && !st) return 1'b0;
    if (c[3] && !(gd && !st)) return gd;
    return c[2] ^ (c[1] & l) ^ (c[0] & ng);
  endfunction : up_f

  // positive integer to truncated encoding plus residue
  function automatic void fpos(input logic [71:0] x, input int f, input int bs,
                               output logic [71:0] en, output logic gd, output logic st);
    int          p;
    logic [71:0] h;
    p = 0;
    for (int i = 0; i < 72; i++) begin
      if (x[i]) p = i;
    end
    h = x & ~(72'h1 << p);
    gd = 1'b0;
    st = 1'b0;
    if (p > f) begin
      gd = x[p-f-1];
      st = |(x & ((72'h1 << (p-f-1)) - 72'h1));
      h = h >> (p - f);
    end else h = h << (f - p);
    en = (72'(p + bs) << f) | h;
  endfunction : fpos

  // Watchdog sized well past the roughly nine hundred cycles the tests need
  initial begin
    #(40 * 20000);
    miscompares++;
    end_of_test();
  end

  // Main sequence
  initial begin
    seed = $urandom(32'h5443);
    repeat (3) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    #5;
    cmp_word(72'(rounding_control_out), 72'h0c);
    foreach (pr[i]) begin
      for (int j = 0; j < 6; j++) begin
        v = (j == 0) ? (72'h1 << (wds[i] - 1)) : {8'($urandom), 32'($urandom), 32'($urandom)};
        run(fru_pkg::FRU_OP_NEG, pr[i], v);
        cmp_word(r.result, sx(-v, wds[i]));
        cmp_flag(r.invalid, j == 0);
      end
    end
    run(fru_pkg::FRU_OP_NEG, fru_pkg::FRU_HALF, 72'o232000);
    cmp_word(r.result, sx(72'o546000, 18));
    run(fru_pkg::FRU_OP_NEG, fru_pkg::FRU_HALF, 72'o214442);
    cmp_word(72'(r.result[16:12]), 72'h0e);  // ones complement of 5'o21
    foreach (sp[i]) begin
      foreach (sp[j]) begin
        run(fru_pkg::FRU_OP_CMP, fru_pkg::FRU_SINGLE, sp[i], sp[j]);
        cmp_flag(r.less, i < j);
        cmp_flag(r.equal, i == j);
      end
    end
    for (int i = 0; i < 8; i++) begin
      v = {8'($urandom), 32'($urandom), 32'($urandom)};
      n = {8'($urandom), 32'($urandom), 32'($urandom)};
      run(fru_pkg::FRU_OP_CMP, fru_pkg::FRU_DOUBLE, v, n);
      cmp_flag(r.less, $signed(v) < $signed(n));
    end
    // write then read back to back
    foreach (modes[i]) begin
      put(fru_pkg::FRU_OP_WRRC, fru_pkg::FRU_SINGLE, 72'(modes[i]));
      put(fru_pkg::FRU_OP_RDRC, fru_pkg::FRU_SINGLE, '0);
      take();
      take();
      cmp_word(r.result, 72'(modes[i]));
      cmp_word(72'(rounding_control_out), 72'(modes[i]));
    end
    run(fru_pkg::FRU_OP_WRRC, fru_pkg::FRU_SINGLE, 72'h11);
    cmp_flag(r.reserved_err, 1'b1);
    cmp_word(72'(rounding_control_out), 72'h01);
    foreach (modes[i]) begin
      run(fru_pkg::FRU_OP_WRRC, fru_pkg::FRU_HALF, 72'(modes[i]));
      foreach (nv[j]) begin
        for (int k = 0; k < 4; k++) begin
          g = k[1];
          s = k[0];
          run(fru_pkg::FRU_OP_ROUND, fru_pkg::FRU_HALF, nv[j], '0, g, s);
          u = up_f(modes[i], nv[j][0], g, s, nv[j][17]);
          ex = (u && nv[j] == 72'h1ffff) ? nv[j] : sx(nv[j] + 72'(u), 18);
          cmp_word(r.result, ex);
          cmp_flag(r.inexact, g | s);
        end
      end
    end
    run(fru_pkg::FRU_OP_ROUND, fru_pkg::FRU_HALF, 72'h20000);
    cmp_flag(r.invalid, 1'b1);
    foreach (pr[i]) begin
      run(fru_pkg::FRU_OP_FLOAT, pr[i], 72'h1);
      cmp_word(r.result, 72'(bss[i]) << fws[i]);
    end
    run(fru_pkg::FRU_OP_FLOAT, fru_pkg::FRU_HALF, 72'd10);
    cmp_word(r.result, 72'o232000);
    run(fru_pkg::FRU_OP_FLOAT, fru_pkg::FRU_HALF, '0);
    cmp_word(r.result, '0);
    for (int i = 0; i < 24; i++) begin
      rc = modes[i % 6];
      run(fru_pkg::FRU_OP_WRRC, fru_pkg::FRU_SINGLE, 72'(rc));
      v = 72'($urandom >> ($urandom % 31)) | 72'h1;
      fpos(v, 26, 256, n, g, s);
      run(fru_pkg::FRU_OP_FLOAT, fru_pkg::FRU_SINGLE, v);
      cmp_word(r.result, n + 72'(up_f(rc, n[0], g, s, 1'b0)));
      cmp_flag(r.inexact, g | s);
      v = v & 72'hfffff;
      fpos(v, 26, 256, n, g, s);
      run(fru_pkg::FRU_OP_FLOAT, fru_pkg::FRU_SINGLE, -v);
      cmp_word(r.result, sx(-n, 36));
    end
    // float to integer under its own modifier
    for (int i = 0; i < 12; i++) begin
      e = $urandom % 34;
      v = (72'(e + 256) << 26) | 72'($urandom % (1 << 26));
      n = (72'h1 << 26) | (v & 72'h3ffffff);
      g = 1'b0;
      s = 1'b0;
      if (e >= 26) n = n << (e - 26);
      else begin
        g = n[25-e];
        s = |(n & ((72'h1 << (25 - e)) - 72'h1));
        n = n >> (26 - e);
      end
      rc = modes[$urandom % 6];
      run(fru_pkg::FRU_OP_FIX, fru_pkg::FRU_SINGLE, v, '0, 1'b0, 1'b0, rc);
      cmp_word(r.result, n + 72'(up_f(rc, n[0], g, s, 1'b0)));
    end
    run(fru_pkg::FRU_OP_FIX, fru_pkg::FRU_SINGLE, 72'(291) << 26);
    cmp_flag(r.overflow, 1'b1);
    cmp_word(r.result, fru_pkg::SINGLE_MAX);
    run(fru_pkg::FRU_OP_FIX, fru_pkg::FRU_SINGLE, 72'h8_0000_0000);
    cmp_flag(r.invalid, 1'b1);
    end_of_test();
  end
endmodule : fru_unit_test
